// >>> hw/cdb_alu.sv
// execution datapath for compare, decrement, decrement-and-skip and decimal adjust
// assumes decode on the same clock presents operands with req_valid and honours req_ready;
// the register file and status logic apply the write-back strobes one cycle after a take
`timescale 1ns/1ps
// Behaviour
// - compare computes file minus working, updates zero and carry only, one cycle
// - decrement file operand, destination bit picks working or file, updates zero, one cycle
// - decimal adjust converts working register sum, writes it back, updates carry only
// - decrement-and-skip stores by destination; zero result discards prefetch, takes two cycles
module cdb_alu import cdb_pkg::*; #(
    parameter int DATA_W = CDB_DATA_W // operand width, fixed at eight by the flags
) (
    input wire logic clk, // core clock, 100 MHz
    input wire logic rst, // synchronous reset, active high
    input wire logic req_valid, // decode presents an operation
    input cdb_req_s req, // operation, destination and operands
    input wire logic add_retired, // pulse: an addition retired this cycle
    output logic req_ready, // operation may be taken this cycle
    output cdb_wb_s wb, // write-back strobes and values, one cycle
    output logic done, // pulse: operation completed
    output logic null_slot, // pulse: prefetched instruction is discarded
    output logic illegal_op, // pulse: unknown operation code was taken
    output logic adjust_in_order, // with done: the adjust directly followed an addition
    output logic busy // level: a two-cycle operation is in progress
);
    cdb_state_e state;
    cdb_state_e next_state;
    logic take;

    logic [8:0] diff;
    logic [7:0] minus_one;
    logic minus_zero;
    logic [7:0] bcd_value;
    logic bcd_carry;
    cdb_wb_s next_wb;
    logic next_illegal;
    logic next_skip;
    logic add_pending;

    assign req_ready = (state == CDB_ST_IDLE);
    assign take = req_valid && req_ready;
    assign busy = (state == CDB_ST_NULL);

    // nine-bit difference: the borrow bit gives the carry of a subtraction
    assign diff = {1'b0, req.file_val} - {1'b0, req.work_val};
    assign minus_one = req.file_val - CDB_ONE;
    assign minus_zero = (minus_one == CDB_ZERO);

    cdb_bcd_adjust u_bcd (
        .sum(req.work_val),
        .carry_in(req.carry_in),
        .half_in(req.half_in),
        .adjusted(bcd_value),
        .carry_out(bcd_carry)
    );

    // decode the operation into its write-back
    always_comb begin
        next_wb = CDB_WB_RST;
        next_illegal = 1'b0;
        next_skip = 1'b0;
        unique case (req.op)
            CDB_OP_COMPARE: begin
                // neither operand is written; only the flags move
                next_wb.zero_we = 1'b1;
                next_wb.zero = (diff[7:0] == CDB_ZERO);
                next_wb.carry_we = 1'b1;
                next_wb.carry = ~diff[8];
            end
            CDB_OP_SUB_ONE: begin
                next_wb.data = minus_one;
                next_wb.work_we = (req.dest == CDB_DEST_WORK);
                next_wb.file_we = (req.dest == CDB_DEST_FILE);
                next_wb.zero_we = 1'b1;
                next_wb.zero = minus_zero;
            end
            CDB_OP_SUB_SKIP: begin
                next_wb.data = minus_one;
                next_wb.work_we = (req.dest == CDB_DEST_WORK);
                next_wb.file_we = (req.dest == CDB_DEST_FILE);
                next_wb.zero_we = 1'b1;
                next_wb.zero = minus_zero;
                next_skip = minus_zero;
            end
            CDB_OP_BCD_ADJ: begin
                // the flags used are those of the preceding addition, so order matters
                next_wb.data = bcd_value;
                next_wb.work_we = 1'b1;
                next_wb.carry_we = 1'b1;
                next_wb.carry = bcd_carry;
            end
            default: begin
                // unknown codes complete as a no-operation so decode cannot hang
                next_illegal = 1'b1;
            end
        endcase
    end

    // sequencing: a zero result of decrement-and-skip adds one null slot
    always_comb begin
        next_state = state;
        unique case (state)
            CDB_ST_IDLE: begin
                if (take && next_skip) begin
                    next_state = CDB_ST_NULL;
                end
            end
            CDB_ST_NULL: begin
                next_state = CDB_ST_IDLE;
            end
            default: begin
                next_state = CDB_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= CDB_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // write-back is issued in the cycle after the take, one strobe cycle only
    always_ff @(posedge clk) begin
        if (rst) begin
            wb <= CDB_WB_RST;
        end else if (take) begin
            wb <= next_wb;
        end else begin
            wb <= CDB_WB_RST;
        end
    end

    // completion: plain operations and non-zero skips finish on the write-back, a zero-result skip one cycle later
    always_ff @(posedge clk) begin
        if (rst) begin
            done <= 1'b0;
        end else begin
            done <= (take && !next_skip) || (state == CDB_ST_NULL);
        end
    end

    // the null slot replaces the prefetched instruction in the first cycle after the take, with the write-back
    always_ff @(posedge clk) begin
        if (rst) begin
            null_slot <= 1'b0;
        end else begin
            null_slot <= take && next_skip;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            illegal_op <= 1'b0;
        end else begin
            illegal_op <= take && next_illegal;
        end
    end

    // remembers that the last retired instruction was an addition; any taken operation clears it,
    // and a new addition in the same cycle wins over that clear
    always_ff @(posedge clk) begin
        if (rst) begin
            add_pending <= 1'b0;
        end else if (add_retired) begin
            add_pending <= 1'b1;
        end else if (take) begin
            add_pending <= 1'b0;
        end
    end

    // only a report: the adjust still runs when software broke the pairing
    always_ff @(posedge clk) begin
        if (rst) begin
            adjust_in_order <= 1'b0;
        end else begin
            adjust_in_order <= take && (req.op == CDB_OP_BCD_ADJ) && add_pending;
        end
    end

endmodule : cdb_alu

// >>> hw/cdb_pkg.sv
// package for the compare / decrement / decimal adjust datapath
// assumes one core clock, synchronous active-high reset and a decoder on the same clock
package cdb_pkg;

    localparam int CDB_DATA_W = 8;

    // operation codes from instruction decode; unused codes are illegal
    typedef enum logic [2:0] {
        CDB_OP_COMPARE = 3'b000, // compare_op
        CDB_OP_SUB_ONE = 3'b001, // subtract_one_op
        CDB_OP_SUB_SKIP = 3'b010, // subtract_one_skip_null_op
        CDB_OP_BCD_ADJ = 3'b011 // bcd_adjust_op
    } cdb_op_e;

    typedef enum logic [1:0] {
        CDB_ST_IDLE = 2'b00,
        CDB_ST_NULL = 2'b01
    } cdb_state_e;

    // destination bit: 0 working register, 1 file register
    localparam logic CDB_DEST_WORK = 1'b0;
    localparam logic CDB_DEST_FILE = 1'b1;

    // decimal adjust constants
    localparam logic [3:0] CDB_NIBBLE_MAX = 4'h9;
    localparam logic [3:0] CDB_BCD_FIX = 4'h6;

    localparam logic [7:0] CDB_DATA_RST = 8'h00;
    localparam logic [7:0] CDB_ONE = 8'h01;
    localparam logic [7:0] CDB_ZERO = 8'h00;

    // execution lengths in cycles
    localparam int CDB_CYCLES_PLAIN = 1;
    localparam int CDB_CYCLES_SKIP = 2;

    typedef struct packed {
        cdb_op_e op;
        logic dest;
        logic [7:0] file_val;
        logic [7:0] work_val;
        logic carry_in;
        logic half_in;
    } cdb_req_s;

    typedef struct packed {
        logic work_we;
        logic file_we;
        logic [7:0] data;
        logic zero_we;
        logic zero;
        logic carry_we;
        logic carry;
    } cdb_wb_s;

    localparam cdb_wb_s CDB_WB_RST = '{
        work_we: 1'b0, file_we: 1'b0, data: 8'h00,
        zero_we: 1'b0, zero: 1'b0, carry_we: 1'b0, carry: 1'b0
    };

endpackage : cdb_pkg

// >>> hw/cdb_bcd_adjust.sv
// combinational decimal adjust of an 8-bit binary sum
// assumes carry and half carry are the flags left by the preceding addition
`timescale 1ns/1ps
module cdb_bcd_adjust import cdb_pkg::*; (
    input wire logic [7:0] sum, // binary sum to correct
    input wire logic carry_in, // carry from the addition
    input wire logic half_in, // half carry from the addition
    output logic [7:0] adjusted, // packed decimal result
    output logic carry_out // decimal overflow
);
    logic fix_low;
    logic [8:0] step_low;
    logic fix_high;
    logic [8:0] step_high;

    always_comb begin
        fix_low = (sum[3:0] > CDB_NIBBLE_MAX) || half_in;
        step_low = {1'b0, sum} + (fix_low ? {5'h00, CDB_BCD_FIX} : 9'h000);
        // a low fix can carry into and beyond the high nibble, so judge the high nibble after it
        fix_high = (step_low[7:4] > CDB_NIBBLE_MAX) || carry_in || step_low[8];
        step_high = {1'b0, step_low[7:0]} + (fix_high ? {1'b0, CDB_BCD_FIX, 4'h0} : 9'h000);
        adjusted = step_high[7:0];
        carry_out = carry_in || step_low[8] || step_high[8];
    end

endmodule : cdb_bcd_adjust

// >>> sim/cdb_alu_chk.sv
// assertions on the ports of the compare / decrement / adjust datapath
// assumes it is bound to cdb_alu and sees only that module's ports
`timescale 1ns/1ps
module cdb_alu_chk import cdb_pkg::*; (
    input wire logic clk, // core clock
    input wire logic rst, // sync reset
    input wire logic req_valid, // request
    input cdb_req_s req, // operands
    input wire logic add_retired, // addition retired
    input wire logic req_ready, // take allowed
    input cdb_wb_s wb, // write-back
    input wire logic done, // complete
    input wire logic null_slot, // discard prefetch
    input wire logic illegal_op, // bad code
    input wire logic adjust_in_order, // adjust after add
    input wire logic busy // two-cycle op
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic take;
    assign take = req_valid && req_ready;
    // reference adjust, kept apart from the datapath on purpose
    function automatic logic [8:0] bcd(input logic [7:0] s, input logic c, input logic h);
        logic [8:0] t;
        t = {1'b0, s} + ((h || s[3:0] > 4'h9) ? 9'h006 : 9'h000);
        if (c || t[8] || t[7:4] > 4'h9) t = t + 9'h060;
        return {c | t[8], t[7:0]};
    endfunction : bcd
    cmp_flags_a: assert property (
        take && req.op == CDB_OP_COMPARE |=> done && !wb.work_we && !wb.file_we && wb.zero_we && wb.carry_we
        && wb.carry == ($past(req.file_val) >= $past(req.work_val)) && wb.zero == ($past(req.file_val) == $past(req.work_val)))
        else $error("compare result wrong");
    sub_dest_a: assert property (
        take && req.op == CDB_OP_SUB_ONE |=> done && wb.data == 8'($past(req.file_val) - 8'h01) && wb.zero_we
        && wb.file_we == $past(req.dest) && wb.work_we != $past(req.dest) && !wb.carry_we) else $error("decrement wrong");
    adj_flags_a: assert property (
        take && req.op == CDB_OP_BCD_ADJ |=> wb.work_we && !wb.file_we && !wb.zero_we && wb.carry_we)
        else $error("adjust strobes wrong");
    adj_value_a: assert property (
        take && req.op == CDB_OP_BCD_ADJ |=> {wb.carry, wb.data} == bcd($past(req.work_val), $past(req.carry_in), $past(req.half_in)))
        else $error("adjust value wrong");
    adj_order_a: assert property (
        take && req.op == CDB_OP_BCD_ADJ && $past(add_retired) |=> adjust_in_order && done)
        else $error("adjust order flag missing");
    skip_null_a: assert property (
        take && req.op == CDB_OP_SUB_SKIP && req.file_val == 8'h01 |=> null_slot && busy && !req_ready && !done ##1 done && !busy)
        else $error("zero skip timing wrong");
    skip_short_a: assert property (
        take && req.op == CDB_OP_SUB_SKIP && req.file_val != 8'h01 |=> done && !null_slot && !busy)
        else $error("non-zero skip wrong");
    cover property (null_slot);
    cover property (adjust_in_order);
    cover property (take && req.op == CDB_OP_COMPARE);
endmodule : cdb_alu_chk
bind cdb_alu cdb_alu_chk u_chk (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .add_retired(add_retired),
    .req_ready(req_ready), .wb(wb), .done(done), .null_slot(null_slot), .illegal_op(illegal_op),
    .adjust_in_order(adjust_in_order), .busy(busy));

// >>> sim/cdb_alu_tb.sv
// self-checking bench for the compare / decrement / adjust datapath
// assumes cdb_alu with its bound checker; inputs change on the falling edge
`timescale 1ns/1ps
module cdb_alu_tb import cdb_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    cdb_req_s req = '0;
    logic add_retired = 1'b0;
    logic req_ready, done, null_slot, illegal_op, adjust_in_order, busy;
    cdb_wb_s wb;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    cdb_alu u_cdb_alu (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .add_retired(add_retired),
        .req_ready(req_ready), .wb(wb), .done(done), .null_slot(null_slot), .illegal_op(illegal_op),
        .adjust_in_order(adjust_in_order), .busy(busy));
    task automatic summarize();
        $display("checks %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // lets one clock edge pass first, so valid never rises in the time step that lowered it;
    // returns at the falling edge after the take
    task automatic issue(input cdb_op_e op, input logic d, input logic [7:0] f, input logic [7:0] w,
                         input logic c, input logic h);
        @(negedge clk);
        add_retired = 1'b0;
        while (!req_ready) begin
            @(negedge clk);
        end
        req = '{op: op, dest: d, file_val: f, work_val: w, carry_in: c, half_in: h};
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
    endtask : issue
    task automatic t_cmp(input logic [7:0] f, input logic [7:0] w, input logic z, input logic c);
        issue(CDB_OP_COMPARE, 1'b1, f, w, 1'b0, 1'b0);
        chk("compare", {2'b00, z, c, 5'b11001}, {1'b0, illegal_op, wb.zero, wb.carry, wb.zero_we, wb.carry_we,
            wb.work_we, wb.file_we, done});
    endtask : t_cmp
    task automatic t_sub(input logic [7:0] f, input logic d);
        issue(CDB_OP_SUB_ONE, d, f, 8'h5a, 1'b1, 1'b1);
        chk("dec data", {1'b0, 8'(f - 8'h01)}, {1'b0, wb.data});
        chk("dec ctl", {3'b000, !d, d, 1'b1, f == 8'h01, 2'b01}, {3'b000, wb.work_we, wb.file_we, wb.zero_we,
            wb.zero, wb.carry_we, done});
    endtask : t_sub
    task automatic t_skip(input logic [7:0] f, input logic d);
        issue(CDB_OP_SUB_SKIP, d, f, 8'h00, 1'b0, 1'b0);
        chk("skip data", {1'b0, 8'(f - 8'h01)}, {1'b0, wb.data});
        chk("skip we", {5'b00000, !d, d, 1'b1, f == 8'h01}, {5'b00000, wb.work_we, wb.file_we, wb.zero_we,
            wb.zero});
        if (f == 8'h01) begin
            chk("skip c1", {5'b00000, 4'b1100}, {5'b00000, null_slot, busy, req_ready, done});
            @(negedge clk);
        end
        chk("skip end", {5'b00000, 4'b0011}, {5'b00000, null_slot, busy, req_ready, done});
    endtask : t_skip
    task automatic t_adj(input logic [7:0] s, input logic c, input logic h, input logic [8:0] exp,
                         input logic paired);
        // the addition retires in the cycle just before the adjust is presented
        add_retired = paired;
        // interrupts stay out of the gap between addition and adjust
        issue(CDB_OP_BCD_ADJ, 1'b0, 8'h00, s, c, h);
        chk("adj value", exp, {wb.carry, wb.data});
        chk("adj ctl", {3'b000, 4'b1001, paired, 1'b1}, {3'b000, wb.work_we, wb.file_we, wb.zero_we,
            wb.carry_we, adjust_in_order, done});
    endtask : t_adj
    // an unknown code must finish with no write-back at all
    task automatic t_bad();
        issue(cdb_op_e'(3'b111), 1'b1, 8'h01, 8'h01, 1'b1, 1'b1);
        chk("illegal", {2'b00, 7'b0000011}, {2'b00, wb.work_we, wb.file_we, wb.zero_we, wb.carry_we,
            adjust_in_order, illegal_op, done});
    endtask : t_bad
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_cmp(8'h34, 8'h12, 1'b0, 1'b1);
        t_cmp(8'h12, 8'h12, 1'b1, 1'b1);
        t_cmp(8'h00, 8'h01, 1'b0, 1'b0);
        t_sub(8'h01, 1'b1);
        t_sub(8'h00, 1'b0);
        t_skip(8'h01, 1'b1);
        t_skip(8'h05, 1'b0);
        t_skip(8'h01, 1'b0);
        t_adj(8'h4d, 1'b0, 1'b0, 9'h053, 1'b1);
        t_adj(8'h12, 1'b0, 1'b1, 9'h018, 1'b1);
        t_adj(8'h20, 1'b1, 1'b0, 9'h180, 1'b1);
        t_adj(8'h9a, 1'b0, 1'b0, 9'h100, 1'b1);
        t_adj(8'h4d, 1'b0, 1'b0, 9'h053, 1'b0);
        t_bad();
        summarize();
    end
endmodule : cdb_alu_tb
